/* src/mgp_pkg.sv */
// shared constants and carrier types for the mii/gmii phy-side interface
package mgp_pkg;
    localparam int BYTE_W = 8;
    localparam int NIB_W = 4;
    localparam int NIB_LO = 0;
    localparam int NIB_HI = 4;
    localparam int SYNC_STAGES = 3;
    localparam real MCLK_MHZ = 25.0;
    localparam real GTX_MHZ = 125.0;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [3:0] NIB_ZERO = 4'h0;
    localparam logic [2:0] SYNC_IDLE = 3'h0;
    localparam logic [2:0] SYNC_RST_ACTIVE = 3'h0;
    localparam logic DDR_RISE_VAL = 1'h0;
    localparam logic DDR_FALL_VAL = 1'h1;

    // transmit pin group, held in the output boundary flops
    typedef struct packed {
        logic en;
        logic er;
        logic [7:0] d;
    } mgp_tx_pins_t;

    // receive pin group, held in the input boundary flops
    typedef struct packed {
        logic dv;
        logic er;
        logic [7:0] d;
    } mgp_rx_pins_t;

    localparam mgp_tx_pins_t TX_PINS_IDLE = '{en: 1'h0, er: 1'h0, d: 8'h00};
    localparam mgp_rx_pins_t RX_PINS_IDLE = '{dv: 1'h0, er: 1'h0, d: 8'h00};

    // nibble phase of the 4-bit path
    typedef enum logic {
        NIB_PH_LOW,
        NIB_PH_HIGH
    } mgp_nib_phase_t;
endpackage

/* src/mgp_phy_if.sv */
// phy-side interface logic: mii nibble path, gmii byte path, clock forward, col/crs sync
`timescale 1ns/1ps
`default_nettype none

module mgp_phy_if (
    // transmit clock domain
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // receive clock from the phy
    input wire logic rx_clk_i,
    // mode strap: high selects gmii, low selects mii
    input wire logic gmii_sel_i,
    // user transmit stream
    input wire logic [7:0] tx_data_i,
    input wire logic tx_valid_i,
    input wire logic tx_err_i,
    output logic tx_ready_o,
    // user receive stream
    output logic [7:0] rx_data_o,
    output logic rx_valid_o,
    output logic rx_err_o,
    output logic rx_end_o,
    // phy transmit pins
    output logic [7:0] phy_txd_o,
    output logic phy_tx_en_o,
    output logic phy_tx_er_o,
    output logic phy_gtx_clk_o,
    // phy receive pins
    input wire logic [7:0] phy_rxd_i,
    input wire logic phy_rx_dv_i,
    input wire logic phy_rx_er_i,
    // half-duplex status pins and their synchronised copies
    input wire logic phy_col_i,
    input wire logic phy_crs_i,
    output logic col_o,
    output logic crs_o
);

    ////////////////////////////////////////////////////////////////////////////
    // mode strap sync into the transmit domain
    logic [2:0] tx_mode_sync_reg;
    logic tx_gmii_reg;
    logic tx_gmii_next;

    always_ff @(posedge mclk_i) begin
        tx_mode_sync_reg <= {tx_mode_sync_reg[1:0], gmii_sel_i};
    end

    assign tx_gmii_next = (tx_mode_sync_reg[1] == tx_mode_sync_reg[2]) ?
                          tx_mode_sync_reg[2] : tx_gmii_reg;

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            tx_gmii_reg <= 1'h0;
        end else begin
            tx_gmii_reg <= tx_gmii_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // transmit path, all on mclk_i (phy clock on mii, local 125 MHz on gmii)
    mgp_pkg::mgp_tx_pins_t tx_pins_reg;
    mgp_pkg::mgp_tx_pins_t tx_pins_next;
    mgp_pkg::mgp_nib_phase_t tx_phase_reg;
    mgp_pkg::mgp_nib_phase_t tx_phase_next;
    logic [3:0] tx_hi_reg;
    logic [3:0] tx_hi_next;
    logic tx_er_hold_reg;
    logic tx_er_hold_next;
    logic tx_ready_reg;
    logic tx_ready_next;
    logic tx_take;

    assign tx_take = tx_valid_i && tx_ready_reg;

    // mii: ready low only in the cycle whose edge sends the high nibble
    assign tx_ready_next = tx_gmii_next ? 1'h1 :
                           (tx_phase_next == mgp_pkg::NIB_PH_HIGH) ? 1'h0 : 1'h1;

    always_comb begin
        tx_pins_next = tx_pins_reg;
        tx_phase_next = tx_phase_reg;
        tx_hi_next = tx_hi_reg;
        tx_er_hold_next = tx_er_hold_reg;
        if (tx_gmii_reg) begin
            tx_phase_next = mgp_pkg::NIB_PH_LOW;
            tx_pins_next.en = tx_take;
            tx_pins_next.er = tx_take && tx_err_i;
            tx_pins_next.d = tx_take ? tx_data_i : mgp_pkg::BYTE_ZERO;
        end else if (tx_phase_reg == mgp_pkg::NIB_PH_HIGH) begin
            tx_phase_next = mgp_pkg::NIB_PH_LOW;
            tx_pins_next.en = 1'h1;
            tx_pins_next.er = tx_er_hold_reg;
            tx_pins_next.d = {mgp_pkg::NIB_ZERO, tx_hi_reg};
        end else if (tx_take) begin
            tx_phase_next = mgp_pkg::NIB_PH_HIGH;
            tx_hi_next = tx_data_i[mgp_pkg::NIB_HI +: mgp_pkg::NIB_W];
            tx_er_hold_next = tx_err_i;
            tx_pins_next.en = 1'h1;
            tx_pins_next.er = tx_err_i;
            tx_pins_next.d = {mgp_pkg::NIB_ZERO,
                              tx_data_i[mgp_pkg::NIB_LO +: mgp_pkg::NIB_W]};
        end else begin
            tx_pins_next = mgp_pkg::TX_PINS_IDLE;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            tx_pins_reg <= mgp_pkg::TX_PINS_IDLE;
            tx_phase_reg <= mgp_pkg::NIB_PH_LOW;
            tx_hi_reg <= mgp_pkg::NIB_ZERO;
            tx_er_hold_reg <= 1'h0;
            tx_ready_reg <= 1'h0;
        end else begin
            tx_pins_reg <= tx_pins_next;
            tx_phase_reg <= tx_phase_next;
            tx_hi_reg <= tx_hi_next;
            tx_er_hold_reg <= tx_er_hold_next;
            tx_ready_reg <= tx_ready_next;
        end
    end

    assign tx_ready_o = tx_ready_reg;
    assign phy_txd_o = tx_pins_reg.d;
    assign phy_tx_en_o = tx_pins_reg.en;
    assign phy_tx_er_o = tx_pins_reg.er;

    ////////////////////////////////////////////////////////////////////////////
    // forwarded gmii transmit clock: ddr pair holding 0 on rise, 1 on fall
    logic ddr_rise_reg;
    logic ddr_fall_reg;

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            ddr_rise_reg <= mgp_pkg::DDR_RISE_VAL;
        end else begin
            ddr_rise_reg <= tx_gmii_reg ? mgp_pkg::DDR_RISE_VAL : 1'h0;
        end
    end

    always_ff @(negedge mclk_i) begin
        ddr_fall_reg <= tx_gmii_reg ? mgp_pkg::DDR_FALL_VAL : 1'h0;
    end

    // output mux of the ddr cell; gives the inverse of mclk_i in gmii mode
    assign phy_gtx_clk_o = mclk_i ? ddr_rise_reg : ddr_fall_reg;

    ////////////////////////////////////////////////////////////////////////////
    // collision and carrier sense: three flops, change once stages 2 and 3 agree
    logic [2:0] col_sync_reg;
    logic [2:0] crs_sync_reg;
    logic col_reg;
    logic crs_reg;

    always_ff @(posedge mclk_i) begin
        col_sync_reg <= {col_sync_reg[1:0], phy_col_i};
        crs_sync_reg <= {crs_sync_reg[1:0], phy_crs_i};
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            col_reg <= 1'h0;
            crs_reg <= 1'h0;
        end else begin
            if (col_sync_reg[1] == col_sync_reg[2]) begin
                col_reg <= col_sync_reg[2];
            end
            if (crs_sync_reg[1] == crs_sync_reg[2]) begin
                crs_reg <= crs_sync_reg[2];
            end
        end
    end

    assign col_o = col_reg;
    assign crs_o = crs_reg;

    ////////////////////////////////////////////////////////////////////////////
    // receive domain: reset and mode strap brought onto this instance's rx clock
    logic [2:0] rx_rst_sync_reg;
    logic rx_rst_n;
    logic [2:0] rx_mode_sync_reg;
    logic rx_gmii_reg;

    always_ff @(posedge rx_clk_i) begin
        rx_rst_sync_reg <= {rx_rst_sync_reg[1:0], rst_n_i};
        rx_mode_sync_reg <= {rx_mode_sync_reg[1:0], gmii_sel_i};
    end

    assign rx_rst_n = rx_rst_sync_reg[1] && rx_rst_sync_reg[2];

    always_ff @(posedge rx_clk_i) begin
        if (!rx_rst_n) begin
            rx_gmii_reg <= 1'h0;
        end else if (rx_mode_sync_reg[1] == rx_mode_sync_reg[2]) begin
            rx_gmii_reg <= rx_mode_sync_reg[2];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // receive path on rx_clk_i
    mgp_pkg::mgp_rx_pins_t rx_pins_reg;
    mgp_pkg::mgp_nib_phase_t rx_phase_reg;
    mgp_pkg::mgp_nib_phase_t rx_phase_next;
    logic [3:0] rx_lo_reg;
    logic rx_lo_er_reg;
    logic [7:0] rx_data_reg;
    logic [7:0] rx_data_next;
    logic rx_valid_reg;
    logic rx_valid_next;
    logic rx_err_reg;
    logic rx_err_next;
    logic rx_end_reg;
    logic rx_dv_prev_reg;
    logic rx_nib_hi;

    always_ff @(posedge rx_clk_i) begin
        if (!rx_rst_n) begin
            rx_pins_reg <= mgp_pkg::RX_PINS_IDLE;
        end else begin
            rx_pins_reg <= '{dv: phy_rx_dv_i, er: phy_rx_er_i, d: phy_rxd_i};
        end
    end

    assign rx_nib_hi = rx_pins_reg.dv && (rx_phase_reg == mgp_pkg::NIB_PH_HIGH);
    assign rx_phase_next = (!rx_pins_reg.dv || rx_gmii_reg) ? mgp_pkg::NIB_PH_LOW :
                           rx_nib_hi ? mgp_pkg::NIB_PH_LOW : mgp_pkg::NIB_PH_HIGH;
    assign rx_valid_next = rx_gmii_reg ? rx_pins_reg.dv : rx_nib_hi;
    assign rx_data_next = rx_gmii_reg ? rx_pins_reg.d :
                          {rx_pins_reg.d[mgp_pkg::NIB_LO +: mgp_pkg::NIB_W], rx_lo_reg};
    assign rx_err_next = rx_gmii_reg ? rx_pins_reg.er : (rx_pins_reg.er || rx_lo_er_reg);

    always_ff @(posedge rx_clk_i) begin
        if (!rx_rst_n) begin
            rx_phase_reg <= mgp_pkg::NIB_PH_LOW;
            rx_lo_reg <= mgp_pkg::NIB_ZERO;
            rx_lo_er_reg <= 1'h0;
            rx_data_reg <= mgp_pkg::BYTE_ZERO;
            rx_valid_reg <= 1'h0;
            rx_err_reg <= 1'h0;
            rx_end_reg <= 1'h0;
            rx_dv_prev_reg <= 1'h0;
        end else begin
            rx_phase_reg <= rx_phase_next;
            if (rx_pins_reg.dv && !rx_nib_hi) begin
                rx_lo_reg <= rx_pins_reg.d[mgp_pkg::NIB_LO +: mgp_pkg::NIB_W];
                rx_lo_er_reg <= rx_pins_reg.er;
            end
            rx_valid_reg <= rx_valid_next;
            if (rx_valid_next) begin
                rx_data_reg <= rx_data_next;
                rx_err_reg <= rx_err_next;
            end
            rx_dv_prev_reg <= rx_pins_reg.dv;
            rx_end_reg <= rx_dv_prev_reg && !rx_pins_reg.dv;
        end
    end

    assign rx_data_o = rx_data_reg;
    assign rx_valid_o = rx_valid_reg;
    assign rx_err_o = rx_err_reg;
    assign rx_end_o = rx_end_reg;

    ////////////////////////////////////////////////////////////////////////////
    // checks, transmit domain
    logic tx_mii_steady;
    logic tx_gmii_steady;
    logic rx_gmii_prev_reg;

    assign tx_mii_steady = !tx_gmii_reg && !tx_gmii_next;
    assign tx_gmii_steady = tx_gmii_reg && tx_gmii_next;

    sequence s_nib_lo_then_hi;
        (phy_txd_o[3:0] == $past(tx_data_i[3:0]) && phy_tx_en_o)
        ##1 (phy_txd_o[3:0] == $past(tx_data_i[7:4], 2) && phy_tx_en_o);
    endsequence

    a_tx_ready_alt: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        tx_mii_steady && tx_take |=> !tx_ready_o ##1 tx_ready_o)
        else $error("mii ready not on alternate cycles");

    a_tx_nib_order: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        tx_mii_steady && tx_take ##1 tx_mii_steady |-> s_nib_lo_then_hi)
        else $error("mii transmit nibble order wrong");

    a_tx_gmii_byte: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        tx_gmii_steady && tx_take |=> phy_tx_en_o && phy_txd_o == $past(tx_data_i))
        else $error("gmii byte not on pins one cycle after take");

    a_tx_gmii_ready: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        tx_gmii_steady ##1 tx_gmii_steady |-> tx_ready_o)
        else $error("gmii ready dropped");

    a_gtx_clk_inv: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        tx_gmii_steady ##1 tx_gmii_steady |-> !ddr_rise_reg && ddr_fall_reg)
        else $error("forwarded clock not inverted");

    a_col_agree: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        $changed(col_o) |-> $past(col_sync_reg[2]) == col_o && $past(col_sync_reg[1]) == col_o)
        else $error("collision changed without stage agreement");

    a_crs_agree: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        $changed(crs_o) |-> $past(crs_sync_reg[2]) == crs_o && $past(crs_sync_reg[1]) == crs_o)
        else $error("carrier changed without stage agreement");

    ////////////////////////////////////////////////////////////////////////////
    // checks, receive domain
    always_ff @(posedge rx_clk_i) begin
        rx_gmii_prev_reg <= rx_gmii_reg;
    end

    a_rx_valid_pace: assert property (@(posedge rx_clk_i) disable iff (!rx_rst_n)
        !rx_gmii_reg && !rx_gmii_prev_reg && rx_valid_o |=> !rx_valid_o)
        else $error("mii receive valid on consecutive cycles");

    a_rx_nib_order: assert property (@(posedge rx_clk_i) disable iff (!rx_rst_n)
        !rx_gmii_reg && !rx_gmii_prev_reg && $rose(rx_valid_o) && $past(rx_valid_o, 2) == 1'h0
        |-> rx_data_o == {$past(rx_pins_reg.d[3:0]), $past(rx_pins_reg.d[3:0], 2)})
        else $error("mii receive nibbles assembled in wrong order");

    a_rx_gmii_byte: assert property (@(posedge rx_clk_i) disable iff (!rx_rst_n)
        rx_gmii_reg && rx_pins_reg.dv |=> rx_valid_o && rx_data_o == $past(rx_pins_reg.d))
        else $error("gmii receive byte not passed");

    a_rx_in_reg: assert property (@(posedge rx_clk_i) disable iff (!rx_rst_n)
        phy_rx_dv_i ##1 phy_rx_dv_i && rx_gmii_reg |=> rx_valid_o)
        else $error("receive pins not registered through to stream");

endmodule // mgp_phy_if

`default_nettype wire

/* verif/mgp_phy_model.sv */
// behavioural phy: drives receive pins and status, collects transmitted bytes
`timescale 1ns/1ps
`default_nettype none
module mgp_phy_model (
    // clocks and mode
    input wire logic mclk_i,
    input wire logic rx_clk_i,
    input wire logic gmii_i,
    // pins from the mac
    input wire logic [7:0] txd_i,
    input wire logic tx_en_i,
    // pins to the mac
    output logic [7:0] rxd_o,
    output logic rx_dv_o,
    output logic rx_er_o,
    output logic col_o,
    output logic crs_o
);
    logic [7:0] tx_q[$];
    logic [3:0] lo_nib;
    logic ph;

    initial begin
        rxd_o = 8'h00;
        rx_dv_o = 1'b0;
        rx_er_o = 1'b0;
        col_o = 1'b0;
        crs_o = 1'b0;
        ph = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // transmit pins sampled on the mac transmit clock
    always @(posedge mclk_i) begin
        if (!tx_en_i) begin
            ph <= 1'b0;
        end else if (gmii_i) begin
            tx_q.push_back(txd_i);
        end else if (!ph) begin
            lo_nib <= txd_i[3:0];
            ph <= 1'b1;
        end else begin
            tx_q.push_back({txd_i[3:0], lo_nib});
            ph <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // receive pins change on the falling rx clock edge
    task automatic send(input logic [7:0] b [4], input logic gm);
        for (int i = 0; i < 4; i++) begin
            @(negedge rx_clk_i);
            rx_dv_o = 1'b1;
            rx_er_o = (i == 1);
            rxd_o = gm ? b[i] : {~b[i][3:0], b[i][3:0]};
            if (!gm) begin
                @(negedge rx_clk_i);
                rxd_o = {~b[i][7:4], b[i][7:4]};
            end
        end
        @(negedge rx_clk_i);
        rx_dv_o = 1'b0;
        rx_er_o = 1'b0;
        rxd_o = ~rxd_o;
    endtask

    // status pins move with no relation to either clock
    task automatic set_status(input logic c, input logic s);
        #7;
        col_o = c;
        crs_o = s;
    endtask
endmodule // mgp_phy_model
`default_nettype wire

/* verif/test_mii_gmii_phy_interface.sv */
// self-checking bench for the mii/gmii phy-side interface
`timescale 1ns/1ps
`default_nettype none
module test_mii_gmii_phy_interface;
    logic mclk;
    logic rx_clk = 1'b0;
    logic rst_n, gsel, tx_valid, tx_err, tx_ready;
    logic rx_valid, rx_err, rx_end, tx_en, tx_er, gtx_clk;
    logic rx_dv, rx_er, col_pin, crs_pin, col, crs;
    logic [7:0] tx_data, rx_data, txd, rxd;
    logic [7:0] rx_got[$];
    logic rx_egot[$];
    int er_cyc = 0;
    int gap = 100;
    int min_gap = 100;
    int ends = 0;
    int errors = 0;
    int num_checks = 0;

    mgp_phy_if u_mgp_phy_if (
        .mclk_i(mclk), .rst_n_i(rst_n), .rx_clk_i(rx_clk), .gmii_sel_i(gsel),
        .tx_data_i(tx_data), .tx_valid_i(tx_valid), .tx_err_i(tx_err),
        .tx_ready_o(tx_ready), .rx_data_o(rx_data), .rx_valid_o(rx_valid),
        .rx_err_o(rx_err), .rx_end_o(rx_end), .phy_txd_o(txd),
        .phy_tx_en_o(tx_en), .phy_tx_er_o(tx_er), .phy_gtx_clk_o(gtx_clk),
        .phy_rxd_i(rxd), .phy_rx_dv_i(rx_dv), .phy_rx_er_i(rx_er),
        .phy_col_i(col_pin), .phy_crs_i(crs_pin), .col_o(col), .crs_o(crs));

    mgp_phy_model u_phy (
        .mclk_i(mclk), .rx_clk_i(rx_clk), .gmii_i(gsel), .txd_i(txd),
        .tx_en_i(tx_en), .rxd_o(rxd), .rx_dv_o(rx_dv), .rx_er_o(rx_er),
        .col_o(col_pin), .crs_o(crs_pin));

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    initial begin
        #3;
        forever #7.5 rx_clk = ~rx_clk;
    end

    ////////////////////////////////////////////////////////////////////////
    // receive stream monitor
    always @(posedge rx_clk) begin
        gap <= gap + 1;
        if (rx_valid === 1'b1) begin
            rx_got.push_back(rx_data);
            rx_egot.push_back(rx_err);
            gap <= 0;
            if (gap < min_gap) begin
                min_gap <= gap;
            end
        end
        if (rx_end === 1'b1) begin
            ends <= ends + 1;
        end
    end

    // transmit error pin, counted in transmit clock cycles
    always @(posedge mclk) begin
        if (tx_er === 1'b1) begin
            er_cyc <= er_cyc + 1;
        end
    end

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // four bytes offered back to back; spacing of takes and pin order
    task automatic tx_test(input logic gm);
        logic [7:0] b [4];
        int take [4];
        int cyc;
        int n;
        b = '{8'h12, 8'hC7, 8'h5E, 8'h09};
        u_phy.tx_q = {};
        er_cyc = 0;
        n = 0;
        cyc = 0;
        while (n < 4 && cyc < 40) begin
            @(negedge mclk);
            tx_valid = 1'b1;
            tx_data = b[n];
            tx_err = (n == 2);
            cyc++;
            if (tx_ready === 1'b1) begin
                take[n] = cyc;
                n++;
            end
        end
        @(negedge mclk);
        tx_valid = 1'b0;
        tx_err = 1'b0;
        if (n < 4) begin
            errors++;
            close_out();
        end
        repeat (4) @(negedge mclk);
        check("tx spacing", 8'(take[1] - take[0]), gm ? 8'h01 : 8'h02);
        check("tx spacing", 8'(take[3] - take[2]), gm ? 8'h01 : 8'h02);
        check("tx count", 8'(u_phy.tx_q.size()), 8'h04);
        for (int i = 0; i < 4; i++) begin
            check("tx byte", u_phy.tx_q[i], b[i]);
        end
        check("tx idle", 8'(tx_en), 8'h00);
        check("tx error cycles", 8'(er_cyc), gm ? 8'h01 : 8'h02);
        $display("tx test done mode %0d", gm);
    endtask

    // one frame of four bytes from the phy
    task automatic rx_test(input logic gm);
        logic [7:0] b [4];
        b = '{8'hA5, 8'h3C, 8'hF0, 8'h81};
        rx_got = {};
        rx_egot = {};
        min_gap = 100;
        ends = 0;
        u_phy.send(b, gm);
        repeat (8) @(posedge rx_clk);
        check("rx count", 8'(rx_got.size()), 8'h04);
        for (int i = 0; i < 4; i++) begin
            check("rx byte", rx_got[i], b[i]);
            check("rx error", 8'(rx_egot[i]), (i == 1) ? 8'h01 : 8'h00);
        end
        check("rx spacing", 8'(min_gap), gm ? 8'h00 : 8'h01);
        check("rx end", 8'(ends), 8'h01);
        $display("rx test done mode %0d", gm);
    endtask

    // forwarded clock sampled mid-way through each half period
    task automatic gtx_test(input logic gm);
        @(posedge mclk);
        #10;
        check("gtx high phase", 8'(gtx_clk), 8'h00);
        @(negedge mclk);
        #10;
        check("gtx low phase", 8'(gtx_clk), gm ? 8'h01 : 8'h00);
        $display("gtx test done mode %0d", gm);
    endtask

    // status pin change counted in transmit clock edges
    task automatic stat_test(input logic c, input logic s);
        int k;
        k = 0;
        @(posedge mclk);
        u_phy.set_status(c, s);
        while ({col, crs} !== {c, s} && k < 8) begin
            @(posedge mclk);
            #1;
            k++;
        end
        check("status value", {6'h00, col, crs}, {6'h00, c, s});
        check("status delay", 8'(k >= 2 && k <= 4), 8'h01);
        $display("status test done after %0d edges", k);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'b0;
        gsel = 1'b0;
        tx_data = 8'h00;
        tx_valid = 1'b0;
        tx_err = 1'b0;
        repeat (6) @(negedge mclk);
        check("reset ready", 8'(tx_ready), 8'h00);
        check("reset tx enable", 8'(tx_en), 8'h00);
        rst_n = 1'b1;
        repeat (6) @(negedge mclk);
        check("idle ready", 8'(tx_ready), 8'h01);
        tx_test(1'b0);
        rx_test(1'b0);
        gtx_test(1'b0);
        gsel = 1'b1;
        repeat (6) @(negedge mclk);
        tx_test(1'b1);
        rx_test(1'b1);
        gtx_test(1'b1);
        stat_test(1'b1, 1'b0);
        stat_test(1'b1, 1'b1);
        stat_test(1'b0, 1'b1);
        stat_test(1'b0, 1'b0);
        close_out();
    end
endmodule // test_mii_gmii_phy_interface
`default_nettype wire
